// ---- core/nvc_pkg.sv ----
package nvc_pkg;

   // Register offsets in the processor register space
   localparam logic [8:0] NVC_OFF_DATA_LOW  = 9'h10C;
   localparam logic [8:0] NVC_OFF_ADDR_LOW  = 9'h10D;
   localparam logic [8:0] NVC_OFF_DATA_HIGH = 9'h10E;
   localparam logic [8:0] NVC_OFF_ADDR_HIGH = 9'h10F;
   localparam logic [8:0] NVC_OFF_CONTROL   = 9'h18C;
   localparam logic [8:0] NVC_OFF_UNLOCK    = 9'h18D;

   // Control register field positions
   localparam int unsigned NVC_CTL_SEL   = 7;
   localparam int unsigned NVC_CTL_ABORT = 3;
   localparam int unsigned NVC_CTL_ALLOW = 2;
   localparam int unsigned NVC_CTL_WR    = 1;
   localparam int unsigned NVC_CTL_RD    = 0;

   // Unlock key bytes
   localparam logic [7:0] NVC_KEY_FIRST  = 8'h55;
   localparam logic [7:0] NVC_KEY_SECOND = 8'hAA;

   // Storage geometry
   localparam int unsigned NVC_DATA_DEPTH = 64;
   localparam int unsigned NVC_DATA_AW    = 6;
   localparam int unsigned NVC_PROG_DEPTH = 2048;
   localparam int unsigned NVC_PROG_AW    = 11;
   localparam int unsigned NVC_PROG_DW    = 14;
   localparam int unsigned NVC_HIGH_DW    = 6;
   localparam int unsigned NVC_ADDR_HI_W  = 5;
   localparam logic [13:0] NVC_PROG_ERASED = 14'h3FFF;

   // Reset values
   localparam logic [7:0] NVC_RST_BYTE = 8'h00;
   localparam logic [5:0] NVC_RST_HIGH = 6'h00;
   localparam logic       NVC_RST_BIT  = 1'b0;

   // Timing
   localparam int unsigned NVC_CLK_FREQ_MHZ        = 125;
   localparam int unsigned NVC_DATA_WRITE_TIME_US  = 4000;
   localparam int unsigned NVC_PROG_WRITE_TIME_US  = 2000;
   localparam int unsigned NVC_DATA_WRITE_CYCLES   =
      NVC_DATA_WRITE_TIME_US * NVC_CLK_FREQ_MHZ;
   localparam int unsigned NVC_PROG_WRITE_CYCLES   =
      NVC_PROG_WRITE_TIME_US * NVC_CLK_FREQ_MHZ;
   localparam int unsigned NVC_PROG_READ_CYCLES    = 2;
   localparam int unsigned NVC_CNT_W               = 20;

   // Operation sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROG_READ,
      ST_DATA_WRITE,
      ST_PROG_WRITE
   } nvc_state_e;

   // Unlock sequence states
   typedef enum logic [1:0] {
      UL_IDLE,
      UL_HALF,
      UL_ARMED
   } nvc_unlock_e;

   // One register access from the processor core
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wdata;
      logic       wr;
   } nvc_sfr_req_s;

   // Register offset match
   function automatic logic nvc_hit(input logic [8:0] addr,
                                    input logic [8:0] off);
      return addr == off;
   endfunction : nvc_hit

endpackage : nvc_pkg

// ---- core/nvc_data_mem.sv ----
`timescale 1ns/100ps
// Byte-wide data storage array
module nvc_data_mem
   import nvc_pkg::*;
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   we_i,
   input  wire logic [NVC_DATA_AW-1:0] waddr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic [NVC_DATA_AW-1:0] raddr_i,
   output logic      [7:0]             rdata_o
);

   logic [7:0] mem [NVC_DATA_DEPTH];

   // Byte write at the end of the timed cycle
   always_ff @(posedge clk_sys_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Read is immediate so the value lands on the next cycle
   assign rdata_o = mem[raddr_i];

endmodule : nvc_data_mem

// ---- core/nvc_prog_mem.sv ----
`timescale 1ns/100ps
// Word-wide program flash array with erase-before-program
module nvc_prog_mem
   import nvc_pkg::*;
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   erase_i,
   input  wire logic                   we_i,
   input  wire logic [NVC_PROG_AW-1:0] waddr_i,
   input  wire logic [NVC_PROG_DW-1:0] wdata_i,
   input  wire logic [NVC_PROG_AW-1:0] raddr_i,
   output logic      [NVC_PROG_DW-1:0] rdata_o
);

   logic [NVC_PROG_DW-1:0] mem [NVC_PROG_DEPTH];

   // Erase phase blanks the word, program phase stores the value
   always_ff @(posedge clk_sys_i) begin
      if (erase_i) begin
         mem[waddr_i] <= NVC_PROG_ERASED;
      end else if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[raddr_i];

endmodule : nvc_prog_mem

// ---- core/nvc_ctrl.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - 64 data bytes at 00h..3Fh, moved byte-wide through low address/data.
// - 2K program words at 000h..7FFh, 13-bit address, 14-bit data pair.
// - Address pair spans 256 data bytes or 8K program words.
// - High address and high data take no part in data-storage accesses.
// - Unused upper bits of the high data register read as zero.
// - Program word write erases the location before programming it.
// - Program write stalls the core; peripherals keep running.
// - Interrupts wait out a program write, one instruction runs first.
// - Bulk erase requests from user code are always refused.
// - Unlock port stores nothing, reads zero, only feeds the unlock.
// - Space select: 1 program, 0 data; frozen while busy.
// - Read and write triggers set by software, cleared by hardware only.
// - Reset during a write sets abort flag; address, data, select kept.
// - Write allow cleared by power-up or software only; writes need it set.
// - Write completion clears write trigger and sets sticky done flag.
// - Data read result lands in low data next cycle and is held.
// - Write starts only after 55h then AAh to the unlock port.
// - Write allow must already be set; same-write setting starts nothing.
// - Clearing write allow does not disturb a running write.
// - Data write length comes from an internal timer; done flag marks it.
// - Program read takes two cycles, then word sits in data pair.
// - Program write halts the core; it resumes after the write.
module nvc_ctrl
   import nvc_pkg::*;
#(
   parameter int unsigned DATA_WRITE_CYCLES = NVC_DATA_WRITE_CYCLES,
   parameter int unsigned PROG_WRITE_CYCLES = NVC_PROG_WRITE_CYCLES
)(
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic         external_reset_pin_i,
   input  wire logic         watchdog_timer_reset_i,
   input  wire nvc_sfr_req_s sfr_req_i,
   output logic [7:0]        sfr_rdata_o,
   output logic              sfr_hit_o,
   input  wire logic         irq_pending_i,
   output logic              irq_take_o,
   output logic              core_stall_o,
   output logic              write_done_flag_o,
   input  wire logic         write_done_clr_i,
   input  wire logic         bulk_erase_req_i,
   output logic              bulk_erase_reject_o
);

   // Sequencer and unlock state
   nvc_state_e             state;
   nvc_state_e             next_state;
   nvc_unlock_e            unlock;
   logic [NVC_CNT_W-1:0]   cnt;

   // Software visible registers and the internal stall_q
   logic [7:0]             data_low;
   logic [NVC_HIGH_DW-1:0] data_high;
   logic [7:0]             addr_low;
   logic [7:0]             addr_high;
   logic                   program_space_select;
   logic                   write_allow;
   logic                   write_abort_flag;
   logic                   stall_q;

   // Operands captured when a write starts
   logic [NVC_PROG_AW-1:0] op_addr;
   logic [NVC_PROG_DW-1:0] op_word;

   // Decode and status terms
   logic                   warm_rst;
   logic                   busy;
   logic                   writing;
   logic                   wr_ctl;
   logic                   wr_unlock;
   logic                   wr_dlow;
   logic                   wr_dhigh;
   logic                   wr_alow;
   logic                   wr_ahigh;
   logic                   start_wr;
   logic                   start_rd;
   logic                   data_rd;
   logic                   prog_rd_done;
   logic                   data_wr_done;
   logic                   prog_wr_done;
   logic                   write_done;
   logic [7:0]             dmem_rdata;
   logic [NVC_PROG_DW-1:0] pmem_rdata;
   logic [NVC_PROG_AW-1:0] prog_addr;
   logic [12:0]            full_addr;

   // Memory arrays
   nvc_data_mem u_data_mem (
      .clk_sys_i (clk_sys_i),
      .we_i      (data_wr_done),
      .waddr_i   (op_addr[NVC_DATA_AW-1:0]),
      .wdata_i   (op_word[7:0]),
      .raddr_i   (addr_low[NVC_DATA_AW-1:0]),
      .rdata_o   (dmem_rdata)
   );

   nvc_prog_mem u_prog_mem (
      .clk_sys_i (clk_sys_i),
      .erase_i   (start_wr && wr_ctl && sfr_req_i.wdata[NVC_CTL_SEL]),
      .we_i      (prog_wr_done),
      .waddr_i   (next_state == ST_PROG_WRITE && state == ST_IDLE
                  ? prog_addr : op_addr),
      .wdata_i   (op_word),
      .raddr_i   (prog_addr),
      .rdata_o   (pmem_rdata)
   );

   // Address pair forms a 13-bit pointer; 2K words are implemented
   assign full_addr = {addr_high[NVC_ADDR_HI_W-1:0], addr_low};
   assign prog_addr = full_addr[NVC_PROG_AW-1:0];

   // Register strobes from the core
   always_comb begin
      wr_ctl    = sfr_req_i.wr && nvc_hit(sfr_req_i.addr, NVC_OFF_CONTROL);
      wr_unlock = sfr_req_i.wr && nvc_hit(sfr_req_i.addr, NVC_OFF_UNLOCK);
      wr_dlow   = sfr_req_i.wr && nvc_hit(sfr_req_i.addr, NVC_OFF_DATA_LOW);
      wr_dhigh  = sfr_req_i.wr && nvc_hit(sfr_req_i.addr, NVC_OFF_DATA_HIGH);
      wr_alow   = sfr_req_i.wr && nvc_hit(sfr_req_i.addr, NVC_OFF_ADDR_LOW);
      wr_ahigh  = sfr_req_i.wr && nvc_hit(sfr_req_i.addr, NVC_OFF_ADDR_HIGH);
   end

   // Warm resets abort work but keep the user registers
   assign warm_rst = external_reset_pin_i || watchdog_timer_reset_i;
   assign busy     = state != ST_IDLE;
   assign writing  = state == ST_DATA_WRITE || state == ST_PROG_WRITE;

   // Trigger qualification
   always_comb begin
      start_wr = wr_ctl && sfr_req_i.wdata[NVC_CTL_WR] && !busy
                 && write_allow
                 && unlock == UL_ARMED
                 && !warm_rst;
      start_rd = wr_ctl && sfr_req_i.wdata[NVC_CTL_RD] && !busy
                 && !start_wr && !warm_rst;
      data_rd  = start_rd && !sfr_req_i.wdata[NVC_CTL_SEL];
   end

   // Completion terms
   always_comb begin
      prog_rd_done = state == ST_PROG_READ &&
                     cnt == NVC_CNT_W'(NVC_PROG_READ_CYCLES - 1);
      data_wr_done = state == ST_DATA_WRITE && !warm_rst &&
                     cnt == NVC_CNT_W'(DATA_WRITE_CYCLES - 1);
      prog_wr_done = state == ST_PROG_WRITE && !warm_rst &&
                     cnt == NVC_CNT_W'(PROG_WRITE_CYCLES - 1);
      write_done   = data_wr_done || prog_wr_done;
   end

   // Next sequencer state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (start_wr) begin
               next_state = sfr_req_i.wdata[NVC_CTL_SEL] ? ST_PROG_WRITE
                                                         : ST_DATA_WRITE;
            end else if (start_rd && sfr_req_i.wdata[NVC_CTL_SEL]) begin
               next_state = ST_PROG_READ;
            end
         end
         ST_PROG_READ: begin
            if (prog_rd_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_DATA_WRITE: begin
            if (data_wr_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_PROG_WRITE: begin
            if (prog_wr_done) begin
               next_state = ST_IDLE;
            end
         end
      endcase
      if (warm_rst) begin
         next_state = ST_IDLE;
      end
   end

   // Sequencer register; trigger bits are decoded from it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Cycle counter of the running operation
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || next_state != state) begin
         cnt <= '0;
      end else if (busy) begin
         cnt <= cnt + NVC_CNT_W'(1);
      end
   end

   // Unlock sequence tracker; the port itself stores nothing
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || warm_rst) begin
         unlock <= UL_IDLE;
      end else if (wr_unlock) begin
         if (sfr_req_i.wdata == NVC_KEY_FIRST) begin
            unlock <= UL_HALF;
         end else if (unlock == UL_HALF &&
                      sfr_req_i.wdata == NVC_KEY_SECOND) begin
            unlock <= UL_ARMED;
         end else begin
            unlock <= UL_IDLE;
         end
      end else if (sfr_req_i.wr) begin
         unlock <= UL_IDLE;   // Any other write breaks or uses the sequence
      end
   end

   // Operands latched at write start
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         op_addr <= '0;
         op_word <= '0;
      end else if (start_wr) begin
         op_addr <= sfr_req_i.wdata[NVC_CTL_SEL]
                    ? prog_addr
                    : {{(NVC_PROG_AW-NVC_DATA_AW){1'b0}},
                       addr_low[NVC_DATA_AW-1:0]};
         op_word <= sfr_req_i.wdata[NVC_CTL_SEL]
                    ? {data_high, data_low}
                    : {{NVC_HIGH_DW{1'b0}}, data_low};
      end
   end

   // Address registers, kept across warm resets
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         addr_low  <= NVC_RST_BYTE;
         addr_high <= NVC_RST_BYTE;
      end else begin
         if (wr_alow) begin
            addr_low <= sfr_req_i.wdata;
         end
         if (wr_ahigh) begin
            addr_high <= sfr_req_i.wdata;
         end
      end
   end

   // Low data byte: software writes, data reads, program read results
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         data_low <= NVC_RST_BYTE;
      end else if (data_rd) begin
         data_low <= dmem_rdata;
      end else if (prog_rd_done) begin
         data_low <= pmem_rdata[7:0];
      end else if (wr_dlow) begin
         data_low <= sfr_req_i.wdata;
      end
   end

   // High data byte holds the upper six bits of a program word
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         data_high <= NVC_RST_HIGH;
      end else if (prog_rd_done) begin
         data_high <= pmem_rdata[NVC_PROG_DW-1:8];
      end else if (wr_dhigh) begin
         data_high <= sfr_req_i.wdata[NVC_HIGH_DW-1:0];
      end
   end

   // Space select, frozen while an operation runs
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         program_space_select <= NVC_RST_BIT;
      end else if (wr_ctl && !busy && !warm_rst) begin
         program_space_select <= sfr_req_i.wdata[NVC_CTL_SEL];
      end
   end

   // Write allow: only power-up and software change it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         write_allow <= NVC_RST_BIT;
      end else if (wr_ctl) begin
         write_allow <= sfr_req_i.wdata[NVC_CTL_ALLOW];
      end
   end

   // Abort flag; a warm reset during a write wins over software
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         write_abort_flag <= NVC_RST_BIT;
      end else if (warm_rst && writing) begin
         write_abort_flag <= 1'b1;
      end else if (wr_ctl) begin
         write_abort_flag <= sfr_req_i.wdata[NVC_CTL_ABORT];
      end
   end

   // Sticky write-done flag; a completion beats a clear
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         write_done_flag_o <= NVC_RST_BIT;
      end else if (write_done) begin
         write_done_flag_o <= 1'b1;
      end else if (write_done_clr_i) begin
         write_done_flag_o <= 1'b0;
      end
   end

   // Core halt during program writes; peripherals are not gated
   assign core_stall_o = state == ST_PROG_WRITE;

   // Remembers the stall so one instruction runs before a vector
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         stall_q <= NVC_RST_BIT;
      end else begin
         stall_q <= core_stall_o;
      end
   end

   // Pending interrupts are held through the write and one cycle after
   assign irq_take_o = irq_pending_i && !core_stall_o && !stall_q;

   // Bulk erase is never carried out, only answered with a refusal
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         bulk_erase_reject_o <= NVC_RST_BIT;
      end else begin
         bulk_erase_reject_o <= bulk_erase_req_i;
      end
   end

   // Register read mux; unlock port and reserved bits read zero
   always_comb begin
      sfr_hit_o   = 1'b1;
      sfr_rdata_o = 8'h00;
      unique case (sfr_req_i.addr)
         NVC_OFF_DATA_LOW:  sfr_rdata_o = data_low;
         NVC_OFF_DATA_HIGH: sfr_rdata_o = {2'b00, data_high};
         NVC_OFF_ADDR_LOW:  sfr_rdata_o = addr_low;
         NVC_OFF_ADDR_HIGH: sfr_rdata_o = addr_high;
         NVC_OFF_UNLOCK:    sfr_rdata_o = 8'h00;
         NVC_OFF_CONTROL: begin
            sfr_rdata_o[NVC_CTL_SEL]   = program_space_select;
            sfr_rdata_o[NVC_CTL_ABORT] = write_abort_flag;
            sfr_rdata_o[NVC_CTL_ALLOW] = write_allow;
            sfr_rdata_o[NVC_CTL_WR]    = writing;
            sfr_rdata_o[NVC_CTL_RD]    = state == ST_PROG_READ;
         end
         default: sfr_hit_o = 1'b0;
      endcase
   end

endmodule : nvc_ctrl

// ---- sim/nvc_ctrl_chk.sv ----
`timescale 1ns/100ps
// Port-level checks for the storage access controller
module nvc_ctrl_chk
   import nvc_pkg::*;
#(
   parameter int unsigned DATA_WRITE_CYCLES = NVC_DATA_WRITE_CYCLES,
   parameter int unsigned PROG_WRITE_CYCLES = NVC_PROG_WRITE_CYCLES
)(
   input wire logic         clk_sys_i,
   input wire logic         rst_i,
   input wire logic         external_reset_pin_i,
   input wire logic         watchdog_timer_reset_i,
   input wire nvc_sfr_req_s sfr_req_i,
   input wire logic [7:0]   sfr_rdata_o,
   input wire logic         sfr_hit_o,
   input wire logic         irq_pending_i,
   input wire logic         irq_take_o,
   input wire logic         core_stall_o,
   input wire logic         write_done_flag_o,
   input wire logic         write_done_clr_i,
   input wire logic         bulk_erase_req_i,
   input wire logic         bulk_erase_reject_o
);
   localparam int STALL_MAX = PROG_WRITE_CYCLES + 4;

   // Warm reset from either source
   logic warm;
   assign warm = external_reset_pin_i | watchdog_timer_reset_i;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // Stall ends within the program write time plus four cycles
   sequence s_stall_end;
      ##[1:STALL_MAX] !core_stall_o;
   endsequence

   // Interrupt held one cycle more, then passed on
   sequence s_irq_release;
      !irq_take_o ##1 (irq_take_o == irq_pending_i);
   endsequence

   unlock_reads_zero_a: assert property (
      sfr_req_i.addr == NVC_OFF_UNLOCK |-> sfr_rdata_o == 8'h00)
      else $error("unlock port read not zero");
   high_data_pad_a: assert property (
      sfr_req_i.addr == NVC_OFF_DATA_HIGH |-> sfr_rdata_o[7:6] == 2'b00)
      else $error("high data pad not zero");
   bulk_refused_a: assert property (
      1'b1 |=> bulk_erase_reject_o == $past(bulk_erase_req_i))
      else $error("bulk erase not refused");
   stall_bound_a: assert property (
      $rose(core_stall_o) |-> s_stall_end)
      else $error("stall too long");
   stall_min_a: assert property (
      $fell(core_stall_o) && !$past(warm) |-> $past(core_stall_o, 8))
      else $error("stall too short");
   irq_queue_a: assert property (
      core_stall_o |-> !irq_take_o)
      else $error("interrupt taken in stall");
   irq_after_a: assert property (
      $fell(core_stall_o) && !$past(warm) |-> s_irq_release)
      else $error("interrupt release wrong");
   done_sticky_a: assert property (
      write_done_flag_o && !write_done_clr_i |=> write_done_flag_o)
      else $error("done flag dropped");
   done_on_finish_a: assert property (
      $fell(core_stall_o) && !$past(warm) |-> ##[0:1] write_done_flag_o)
      else $error("done flag missing");
endmodule : nvc_ctrl_chk

// ---- sim/nvc_core_model.sv ----
`timescale 1ns/100ps
// Processor core model issuing register accesses
module nvc_core_model
   import nvc_pkg::*;
(
   input  wire logic   clk_sys_i,
   output nvc_sfr_req_s sfr_req_o
);
   // Quiet bus from time zero
   initial sfr_req_o = '0;

   // One write, taken at the next rising edge
   task automatic put(input logic [8:0] addr, input logic [7:0] data);
      @(negedge clk_sys_i);
      sfr_req_o = '{addr: addr, wdata: data, wr: 1'b1};
   endtask : put

   // Address only, no write strobe
   task automatic look(input logic [8:0] addr);
      @(negedge clk_sys_i);
      sfr_req_o = '{addr: addr, wdata: 8'h00, wr: 1'b0};
   endtask : look

   // Idle cycles on an unmapped address
   task automatic idle(input int n);
      repeat (n) look(9'h000);
   endtask : idle

   // Allow first, keys next, trigger last
   task automatic arm_write(input logic sel, input logic [7:0] k1,
                            input logic [7:0] k2);
      put(NVC_OFF_CONTROL, {sel, 7'b0000100});
      put(NVC_OFF_UNLOCK, k1);
      put(NVC_OFF_UNLOCK, k2);
      put(NVC_OFF_CONTROL, {sel, 7'b0000110});
   endtask : arm_write
endmodule : nvc_core_model

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
// Self-checking bench for the access controller
module testbench
   import nvc_pkg::*;
;
   localparam int unsigned DWC = 20;
   localparam int unsigned PWC = 10;
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } nvc_row_s;

   logic         clk_sys_i = 1'b0;
   logic         rst_i;
   logic         ext_rst;
   logic         wdt_rst;
   nvc_sfr_req_s sfr_req;
   logic [7:0]   rdata;
   logic         hit;
   logic         irq_pend;
   logic         irq_take;
   logic         stall;
   logic         flag;
   logic         clr;
   logic         bulk;
   logic         bulk_rej;
   int           n_errors = 0;
   int           comparisons = 0;
   int           cycles = 0;
   logic [7:0]   dh [2] = '{8'h2A, 8'h15};
   logic [7:0]   dl [2] = '{8'h5C, 8'hA3};
   nvc_row_s     rows [9] = '{
      '{NVC_OFF_DATA_LOW,  8'h5A, 8'h5A},
      '{NVC_OFF_ADDR_LOW,  8'h3F, 8'h3F},
      '{NVC_OFF_ADDR_HIGH, 8'h1F, 8'h1F},
      '{NVC_OFF_DATA_HIGH, 8'hFF, 8'h3F},
      '{NVC_OFF_UNLOCK,    8'h55, 8'h00},
      '{NVC_OFF_CONTROL,   8'hF0, 8'h80},
      '{NVC_OFF_CONTROL,   8'h08, 8'h08},
      '{NVC_OFF_CONTROL,   8'h00, 8'h00},
      '{9'h000,            8'hAB, 8'h00}};

   // Clock and cycle ceiling
   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         wrap_up();
      end
   end

   nvc_core_model core_m (
      .clk_sys_i (clk_sys_i),
      .sfr_req_o (sfr_req)
   );

   nvc_ctrl #(.DATA_WRITE_CYCLES(DWC), .PROG_WRITE_CYCLES(PWC)) i_nvc_ctrl (
      .clk_sys_i              (clk_sys_i),
      .rst_i                  (rst_i),
      .external_reset_pin_i   (ext_rst),
      .watchdog_timer_reset_i (wdt_rst),
      .sfr_req_i              (sfr_req),
      .sfr_rdata_o            (rdata),
      .sfr_hit_o              (hit),
      .irq_pending_i          (irq_pend),
      .irq_take_o             (irq_take),
      .core_stall_o           (stall),
      .write_done_flag_o      (flag),
      .write_done_clr_i       (clr),
      .bulk_erase_req_i       (bulk),
      .bulk_erase_reject_o    (bulk_rej)
   );

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Register read in the current cycle
   task automatic peek(input logic [8:0] addr, input logic [7:0] exp);
      core_m.look(addr);
      #1 check(rdata, exp);
      check({7'h00, hit}, {7'h00, addr != 9'h000});
   endtask : peek

   // Bounded wait for the done flag
   task automatic wait_done();
      int n = 0;
      while (flag !== 1'b1 && n < 100) begin
         core_m.idle(1);
         n++;
      end
      check({7'h00, flag}, 8'h01);
   endtask : wait_done

   // One-cycle clear of the done flag
   task automatic clear_flag();
      @(negedge clk_sys_i) clr = 1'b1;
      @(negedge clk_sys_i) clr = 1'b0;
   endtask : clear_flag

   // Verdict
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   // Main sequence
   initial begin
      rst_i = 1'b1;
      ext_rst = 1'b0;
      wdt_rst = 1'b0;
      irq_pend = 1'b0;
      clr = 1'b0;
      bulk = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i) rst_i = 1'b0;
      peek(NVC_OFF_CONTROL, 8'h00);
      foreach (rows[i]) begin
         core_m.put(rows[i].addr, rows[i].wdata);
         peek(rows[i].addr, rows[i].exp);
      end
      // Data write at the top address, then read back
      core_m.put(NVC_OFF_ADDR_LOW, 8'h3F);
      core_m.put(NVC_OFF_DATA_LOW, 8'hC3);
      core_m.put(NVC_OFF_DATA_HIGH, 8'h15);
      core_m.arm_write(1'b0, NVC_KEY_FIRST, NVC_KEY_SECOND);
      peek(NVC_OFF_CONTROL, 8'h06);
      check({7'h00, flag}, 8'h00);
      core_m.put(NVC_OFF_CONTROL, 8'h85);
      peek(NVC_OFF_CONTROL, 8'h06);
      core_m.put(NVC_OFF_CONTROL, 8'h00);
      peek(NVC_OFF_CONTROL, 8'h02);
      wait_done();
      core_m.idle(3);
      check({7'h00, flag}, 8'h01);
      peek(NVC_OFF_CONTROL, 8'h00);
      clear_flag();
      check({7'h00, flag}, 8'h00);
      core_m.put(NVC_OFF_DATA_LOW, 8'h00);
      core_m.put(NVC_OFF_CONTROL, 8'h01);
      peek(NVC_OFF_DATA_LOW, 8'hC3);
      peek(NVC_OFF_CONTROL, 8'h00);
      // Same-write allow, reversed keys, repeated key
      core_m.put(NVC_OFF_CONTROL, 8'h00);
      core_m.put(NVC_OFF_UNLOCK, NVC_KEY_FIRST);
      core_m.put(NVC_OFF_UNLOCK, NVC_KEY_SECOND);
      core_m.put(NVC_OFF_CONTROL, 8'h06);
      peek(NVC_OFF_CONTROL, 8'h04);
      core_m.arm_write(1'b0, NVC_KEY_SECOND, NVC_KEY_FIRST);
      peek(NVC_OFF_CONTROL, 8'h04);
      core_m.arm_write(1'b0, NVC_KEY_FIRST, NVC_KEY_FIRST);
      peek(NVC_OFF_CONTROL, 8'h04);
      core_m.idle(DWC + 5);
      check({7'h00, flag}, 8'h00);
      // Warm reset from each source in mid-write
      for (int i = 0; i < 2; i++) begin
         core_m.put(NVC_OFF_ADDR_LOW, 8'h2A);
         core_m.arm_write(1'b0, NVC_KEY_FIRST, NVC_KEY_SECOND);
         core_m.idle(3);
         ext_rst = (i == 0);
         wdt_rst = (i == 1);
         core_m.idle(1);
         ext_rst = 1'b0;
         wdt_rst = 1'b0;
         peek(NVC_OFF_CONTROL, 8'h0C);
         peek(NVC_OFF_ADDR_LOW, 8'h2A);
         core_m.idle(DWC + 5);
         check({7'h00, flag}, 8'h00);
         core_m.put(NVC_OFF_CONTROL, 8'h00);
      end
      // Program write, then one cut by a warm reset
      irq_pend = 1'b1;
      for (int k = 0; k < 2; k++) begin
         core_m.put(NVC_OFF_ADDR_HIGH, 8'h07);
         core_m.put(NVC_OFF_ADDR_LOW, 8'h3F);
         core_m.put(NVC_OFF_DATA_HIGH, dh[k]);
         core_m.put(NVC_OFF_DATA_LOW, dl[k]);
         core_m.arm_write(1'b1, NVC_KEY_FIRST, NVC_KEY_SECOND);
         peek(NVC_OFF_CONTROL, 8'h86);
         check({7'h00, stall}, 8'h01);
         check({7'h00, irq_take}, 8'h00);
         @(negedge clk_sys_i) wdt_rst = (k == 1);
         if (k == 0) wait_done();
         core_m.idle(1);
         wdt_rst = 1'b0;
         check({7'h00, stall}, 8'h00);
         clear_flag();
         core_m.put(NVC_OFF_DATA_LOW, 8'h00);
         core_m.put(NVC_OFF_DATA_HIGH, 8'h00);
         core_m.put(NVC_OFF_CONTROL, 8'h81);
         peek(NVC_OFF_CONTROL, 8'h81);
         core_m.idle(1);
         peek(NVC_OFF_DATA_LOW, k ? 8'hFF : dl[k]);
         peek(NVC_OFF_DATA_HIGH, k ? 8'h3F : dh[k]);
      end
      // Bulk erase request
      @(negedge clk_sys_i) bulk = 1'b1;
      @(negedge clk_sys_i) bulk = 1'b0;
      check({7'h00, bulk_rej}, 8'h01);
      wrap_up();
   end
endmodule : testbench

bind nvc_ctrl nvc_ctrl_chk #(
   .DATA_WRITE_CYCLES (DATA_WRITE_CYCLES),
   .PROG_WRITE_CYCLES (PROG_WRITE_CYCLES)
) u_chk (
   .clk_sys_i              (clk_sys_i),
   .rst_i                  (rst_i),
   .external_reset_pin_i   (external_reset_pin_i),
   .watchdog_timer_reset_i (watchdog_timer_reset_i),
   .sfr_req_i              (sfr_req_i),
   .sfr_rdata_o            (sfr_rdata_o),
   .sfr_hit_o              (sfr_hit_o),
   .irq_pending_i          (irq_pending_i),
   .irq_take_o             (irq_take_o),
   .core_stall_o           (core_stall_o),
   .write_done_flag_o      (write_done_flag_o),
   .write_done_clr_i       (write_done_clr_i),
   .bulk_erase_req_i       (bulk_erase_req_i),
   .bulk_erase_reject_o    (bulk_erase_reject_o)
);
